// >>> core/timer_regs.vh
// Purpose: Register map and field layout of the dual counter/timer pulse unit
// Assumes: Avalon-MM word addresses, one 8-bit register per 32-bit word
// Notes:   Offsets are register indices; the byte address is four times that
// Operation
// - Edge detector watches one of two inputs, emits rising or falling pulses.
// - Glitches shorter than the two-bit filter setting are suppressed.
// - Disabled short timer in transmit drives inverse of its initial-value bit.
// - On enable short output takes initial level; loads low or high hold.
// - Single-pass short timer stops at zero, toggles, sets timeout, may interrupt.
// - Modulo-N short timer toggles, reloads per new level, repeats, sets timeout.
// - Hold registers may change anytime; new values apply at next load.
// - Count of 1 is illegal; count of 0 wraps to FFh and continues.
// - Demodulation captures count: rising edge to low, falling to high register.
// - After each capture the short counter reloads FFh and continues down.
// - Short zero in demodulation sets timeout, may interrupt, continues from FFh.
// - Disabled long timer drives inverse of its initial-value bit.
// - Output-control 10 or 11 forces long output to 0 or 1.
// - On enable long timer loads upper*256+lower and drives initial level.
// - Long zero toggles output, sets timeout status, may interrupt.
// - Long timer stops at zero in single-pass, reloads in modulo-N.
// - Low five bits of enable/sync register read 11111, writes ignored.
// - Enable bits read running state; write 0 stops, 1 starts; reset off.
// - Sync-mode bit, 0 disabled, 1 enabled, reset to disabled.
// - Short captures hold phase counts; long captures hold upper, lower byte.
`ifndef TIMER_REGS_VH
`define TIMER_REGS_VH

`define ADDR_W                4
`define OFF_SHORT_CTRL        4'h0
`define OFF_SHARED_MODE       4'h1
`define OFF_LONG_CTRL         4'h2
`define OFF_EN_SYNC           4'h3
`define OFF_SHORT_LOW_HOLD    4'h4
`define OFF_SHORT_HIGH_HOLD   4'h5
`define OFF_LONG_HOLD_LOWER   4'h6
`define OFF_LONG_HOLD_UPPER   4'h7
`define OFF_LONG_CAP_LOWER    4'h8
`define OFF_LONG_CAP_UPPER    4'h9
`define OFF_SHORT_CAP_LOW     4'ha
`define OFF_SHORT_CAP_HIGH    4'hb

// short_timer_control / long_timer_control
`define BIT_SINGLE_PASS       6
`define BIT_TIMEOUT           5
`define BIT_CAP_IE            2
`define BIT_TIMEOUT_IE        1
// shared_timer_mode_control
`define BIT_DEMOD             7
`define BIT_IN_SEL            6
`define BIT_EDGE_HI           5
`define BIT_EDGE_LO           4
`define BIT_F_HI              3
`define BIT_F_LO              2
`define BIT_SHORT_INIT        1
`define BIT_LONG_INIT         0
// timer_enable_sync_control
`define BIT_LONG_EN           7
`define BIT_SHORT_EN          6
`define BIT_SYNC              5
`define EN_SYNC_LOW_BITS      5'h1f

// Glitch filter minimum widths in clock cycles
`define FILT_W0               4'h1
`define FILT_W1               4'h2
`define FILT_W2               4'h4
`define FILT_W3               4'h8

`define CTRL_RESET            8'h00
`define COUNT_RELOAD          8'hff
`define COUNT_ONE             8'h01
`define LONG_ONE              16'h0001

`endif

// >>> core/dual_counter_timer_pulse_unit.v
// Purpose: 8-bit and 16-bit down counters for pulse generation and capture
// Assumes: Synchronous pin inputs, single clock, Avalon-MM register access
// Notes:   Every request waits exactly one cycle, then completes
//          Status bits clear on a written one; a same-cycle set wins
`timescale 1ns/1ps
`include "timer_regs.vh"

module dual_counter_timer_pulse_unit (
  // Clock, reset, enable
  input  wire                 clk,
  input  wire                 arst_n,
  input  wire                 ce,
  // Avalon-MM slave
  input  wire [`ADDR_W-1:0]   avs_address,
  input  wire                 avs_read,
  input  wire                 avs_write,
  input  wire [31:0]          avs_writedata,
  output reg  [31:0]          avs_readdata,
  output wire                 avs_waitrequest,
  // Pins
  input  wire                 capture_input_a,
  input  wire                 capture_input_b,
  output reg                  short_timer_output,
  output reg                  long_timer_output,
  // Interrupt requests
  output wire                 short_timer_irq,
  output wire                 long_timer_irq
);

  // Bus handshake
  reg        ack;
  wire       wr_go = avs_write & ack;
  wire [7:0] wd    = avs_writedata[7:0];
  assign avs_waitrequest = (avs_read | avs_write) & ~ack;

  // Software-visible state
  reg        short_single;
  reg        short_timeout;
  reg        short_cap_ie;
  reg        short_to_ie;
  reg        demod;
  reg        in_sel;
  reg  [1:0] edge_sel;
  reg  [1:0] filt_ctl;
  reg        short_init;
  reg        long_init;
  reg        pos_flag;
  reg        neg_flag;
  reg        long_single;
  reg        long_timeout;
  reg        long_to_ie;
  reg        long_run;
  reg        short_run;
  reg        sync_mode;
  reg  [7:0] short_low_hold;
  reg  [7:0] short_high_hold;
  reg  [7:0] long_hold_lower;
  reg  [7:0] long_hold_upper;
  reg  [7:0] short_cap_low;
  reg  [7:0] short_cap_high;
  reg [15:0] long_cap;

  // Counters
  reg  [7:0] short_count;
  reg [15:0] long_count;

  // Register write strobes
  wire wr_sctl  = wr_go & (avs_address == `OFF_SHORT_CTRL);
  wire wr_mode  = wr_go & (avs_address == `OFF_SHARED_MODE);
  wire wr_lctl  = wr_go & (avs_address == `OFF_LONG_CTRL);
  wire wr_ens   = wr_go & (avs_address == `OFF_EN_SYNC);
  // A one written to a running timer's enable does not restart it
  wire start_s  = wr_ens & wd[`BIT_SHORT_EN] & ~short_run;
  wire stop_s   = wr_ens & ~wd[`BIT_SHORT_EN];
  wire start_l  = wr_ens & wd[`BIT_LONG_EN] & ~long_run;
  wire stop_l   = wr_ens & ~wd[`BIT_LONG_EN];

  // Input select and glitch filter
  reg        filt_level;
  reg  [3:0] stable_cnt;
  reg  [3:0] min_width;
  wire       raw_in = in_sel ? capture_input_b : capture_input_a;

  always @* begin
    case (filt_ctl)
      2'b00:   min_width = `FILT_W0;
      2'b01:   min_width = `FILT_W1;
      2'b10:   min_width = `FILT_W2;
      default: min_width = `FILT_W3;
    endcase
  end

  // Level must differ for min_width cycles before it is accepted
  // Any agreeing cycle restarts the count, so only unbroken widths pass
  wire filt_flip = (raw_in != filt_level) &
                   (stable_cnt + 4'h1 >= min_width);

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      filt_level <= 1'b0;
      stable_cnt <= 4'h0;
    end else if (ce) begin
      if (raw_in == filt_level || filt_flip) begin
        stable_cnt <= 4'h0;
      end else begin
        stable_cnt <= stable_cnt + 4'h1;
      end
      if (filt_flip) begin
        filt_level <= raw_in;
      end
    end
  end

  wire pos_edge = filt_flip & raw_in & edge_sel[0];
  wire neg_edge = filt_flip & ~raw_in & edge_sel[1];
  wire capture  = demod & short_run & (pos_edge | neg_edge);

  // Terminal counts: the count of one steps to zero this cycle
  wire short_zero = short_run & (short_count == `COUNT_ONE);
  wire long_zero  = long_run & (long_count == `LONG_ONE);
  wire short_tx   = ~demod;

  // Status bits: hardware set beats a software clear in the same cycle
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      short_timeout <= 1'b0;
      long_timeout  <= 1'b0;
      pos_flag      <= 1'b0;
      neg_flag      <= 1'b0;
    end else if (ce) begin
      if (short_zero) begin
        short_timeout <= 1'b1;
      end else if (wr_sctl & wd[`BIT_TIMEOUT]) begin
        short_timeout <= 1'b0;
      end
      if (long_zero) begin
        long_timeout <= 1'b1;
      end else if (wr_lctl & wd[`BIT_TIMEOUT]) begin
        long_timeout <= 1'b0;
      end
      if (capture & pos_edge) begin
        pos_flag <= 1'b1;
      end else if (wr_mode & demod & wd[`BIT_SHORT_INIT]) begin
        pos_flag <= 1'b0;
      end
      if (capture & neg_edge) begin
        neg_flag <= 1'b1;
      end else if (wr_mode & demod & wd[`BIT_LONG_INIT]) begin
        neg_flag <= 1'b0;
      end
    end
  end

  // Plain control registers
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      short_single    <= 1'b0;
      short_cap_ie    <= 1'b0;
      short_to_ie     <= 1'b0;
      demod           <= 1'b0;
      in_sel          <= 1'b0;
      edge_sel        <= 2'b00;
      filt_ctl        <= 2'b00;
      short_init      <= 1'b0;
      long_init       <= 1'b0;
      long_single     <= 1'b0;
      long_to_ie      <= 1'b0;
      sync_mode       <= 1'b0;
      short_low_hold  <= `CTRL_RESET;
      short_high_hold <= `CTRL_RESET;
      long_hold_lower <= `CTRL_RESET;
      long_hold_upper <= `CTRL_RESET;
    end else if (ce) begin
      if (wr_sctl) begin
        short_single <= wd[`BIT_SINGLE_PASS];
        short_cap_ie <= wd[`BIT_CAP_IE];
        short_to_ie  <= wd[`BIT_TIMEOUT_IE];
      end
      if (wr_mode) begin
        demod    <= wd[`BIT_DEMOD];
        in_sel   <= wd[`BIT_IN_SEL];
        edge_sel <= wd[`BIT_EDGE_HI:`BIT_EDGE_LO];
        filt_ctl <= wd[`BIT_F_HI:`BIT_F_LO];
        // Low two bits are status flags while demodulating
        if (!demod) begin
          short_init <= wd[`BIT_SHORT_INIT];
          long_init  <= wd[`BIT_LONG_INIT];
        end
      end
      if (wr_lctl) begin
        long_single <= wd[`BIT_SINGLE_PASS];
        long_to_ie  <= wd[`BIT_TIMEOUT_IE];
      end
      if (wr_ens) begin
        sync_mode <= wd[`BIT_SYNC];
      end
      // Holds are only read at a load, so a change waits for the next one
      if (wr_go && avs_address == `OFF_SHORT_LOW_HOLD) begin
        short_low_hold <= wd;
      end
      if (wr_go && avs_address == `OFF_SHORT_HIGH_HOLD) begin
        short_high_hold <= wd;
      end
      if (wr_go && avs_address == `OFF_LONG_HOLD_LOWER) begin
        long_hold_lower <= wd;
      end
      if (wr_go && avs_address == `OFF_LONG_HOLD_UPPER) begin
        long_hold_upper <= wd;
      end
    end
  end

  // Short timer
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      short_run          <= 1'b0;
      short_count        <= `CTRL_RESET;
      short_timer_output <= 1'b1;
      short_cap_low      <= `CTRL_RESET;
      short_cap_high     <= `CTRL_RESET;
    end else if (ce) begin
      if (stop_s) begin
        short_run <= 1'b0;
      end else if (start_s) begin
        short_run <= 1'b1;
        if (demod) begin
          // Measurement starts from a full count
          short_count <= `COUNT_RELOAD;
        end else begin
          short_timer_output <= short_init;
          short_count <= short_init ? short_high_hold
                                    : short_low_hold;
        end
      end else if (short_run && !demod) begin
        if (short_zero) begin
          short_timer_output <= ~short_timer_output;
          if (short_single) begin
            short_run   <= 1'b0;
            short_count <= 8'h00;
          end else if (short_timer_output) begin
            // Output falls to 0, so the low phase is reloaded
            short_count <= short_low_hold;
          end else begin
            short_count <= short_high_hold;
          end
        end else begin
          short_count <= short_count - 8'h01;
        end
      end else if (short_run) begin
        if (capture) begin
          if (pos_edge) begin
            short_cap_low <= short_count;
          end else begin
            short_cap_high <= short_count;
          end
          short_count <= `COUNT_RELOAD;
        end else if (short_zero) begin
          short_count <= `COUNT_RELOAD;
        end else begin
          short_count <= short_count - 8'h01;
        end
      end
      // A stopped transmitter idles at the inverse of its initial level
      if (!short_run && !start_s && short_tx) begin
        short_timer_output <= ~short_init;
      end
    end
  end

  // Long timer
  reg long_state;
  wire [15:0] long_load = {long_hold_upper, long_hold_lower};

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      long_run   <= 1'b0;
      long_count <= 16'h0000;
      long_state <= 1'b1;
      long_cap   <= 16'h0000;
    end else if (ce) begin
      if (stop_l) begin
        long_run <= 1'b0;
      end else if (start_l) begin
        // Count and level change on the enabling edge itself
        long_run   <= 1'b1;
        long_count <= long_load;
        long_state <= long_init;
      end else if (long_run) begin
        if (long_zero) begin
          long_state <= ~long_state;
          if (long_single) begin
            // Parked until software enables it again
            long_run   <= 1'b0;
            long_count <= 16'h0000;
          end else begin
            long_count <= long_load;
          end
        end else begin
          long_count <= long_count - 16'h0001;
        end
      end else begin
        long_state <= ~long_init;
      end
      if (capture) begin
        long_cap <= long_count;
      end
    end
  end

  // Forcing applies only while the field means output control
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      long_timer_output <= 1'b1;
    end else if (ce) begin
      if (short_tx && filt_ctl[1]) begin
        long_timer_output <= filt_ctl[0];
      end else if (!long_run && !start_l) begin
        long_timer_output <= ~long_init;
      end else if (start_l) begin
        long_timer_output <= long_init;
      end else if (long_zero) begin
        long_timer_output <= ~long_state;
      end else begin
        long_timer_output <= long_state;
      end
    end
  end

  // Requests are levels; they drop when the status or its enable clears
  assign short_timer_irq = (short_timeout & short_to_ie) |
                           ((pos_flag | neg_flag) & short_cap_ie);
  assign long_timer_irq  = long_timeout & long_to_ie;

  // Read mux
  // Capture registers and the low enable bits ignore writes
  reg [7:0] rd_byte;
  always @* begin
    case (avs_address)
      `OFF_SHORT_CTRL:      rd_byte = {1'b0, short_single, short_timeout,
                                       2'b00, short_cap_ie, short_to_ie, 1'b0};
      `OFF_SHARED_MODE:     rd_byte = {demod, in_sel, edge_sel, filt_ctl,
                                       demod ? pos_flag : short_init,
                                       demod ? neg_flag : long_init};
      `OFF_LONG_CTRL:       rd_byte = {1'b0, long_single, long_timeout,
                                       3'b000, long_to_ie, 1'b0};
      `OFF_EN_SYNC:         rd_byte = {long_run, short_run, sync_mode,
                                       `EN_SYNC_LOW_BITS};
      `OFF_SHORT_LOW_HOLD:  rd_byte = short_low_hold;
      `OFF_SHORT_HIGH_HOLD: rd_byte = short_high_hold;
      `OFF_LONG_HOLD_LOWER: rd_byte = long_hold_lower;
      `OFF_LONG_HOLD_UPPER: rd_byte = long_hold_upper;
      `OFF_LONG_CAP_LOWER:  rd_byte = long_cap[7:0];
      `OFF_LONG_CAP_UPPER:  rd_byte = long_cap[15:8];
      `OFF_SHORT_CAP_LOW:   rd_byte = short_cap_low;
      `OFF_SHORT_CAP_HIGH:  rd_byte = short_cap_high;
      default:              rd_byte = 8'h00;
    endcase
  end

  // The registered read costs the one wait state every access sees
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ack          <= 1'b0;
      avs_readdata <= 32'h0000_0000;
    end else if (ce) begin
      ack <= (avs_read | avs_write) & ~ack;
      if (avs_read && !ack) begin
        avs_readdata <= {24'h00_0000, rd_byte};
      end
    end
  end

endmodule // dual_counter_timer_pulse_unit

// >>> testbench/timer_monitor.sv
// Purpose: Port-level checks of the dual counter/timer unit
// Assumes: One wait state per access, clock enable held high
// Notes:   Bound to the counter/timer unit by the bind below
`timescale 1ns/1ps
`include "timer_regs.vh"
module timer_monitor (
  // Clock and reset
  input wire               clk,
  input wire               arst_n,
  input wire               ce,
  // Register bus
  input wire [`ADDR_W-1:0] avs_address,
  input wire               avs_read,
  input wire               avs_write,
  input wire [31:0]        avs_writedata,
  input wire [31:0]        avs_readdata,
  input wire               avs_waitrequest,
  // Pins and requests
  input wire               short_timer_output,
  input wire               long_timer_output,
  input wire               short_timer_irq,
  input wire               long_timer_irq
);
  wire wr_done = avs_write && !avs_waitrequest;
  wire rd_done = avs_read && !avs_waitrequest;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  AST_WAIT_ONE: assert property (
    (avs_read || avs_write) && avs_waitrequest && ce |=> !avs_waitrequest)
    else $error("wait state longer than one cycle");
  AST_WAIT_IDLE: assert property (
    !(avs_read || avs_write) |-> !avs_waitrequest)
    else $error("waitrequest without a request");
  AST_READ_UPPER: assert property (
    rd_done |-> avs_readdata[31:8] == 24'h000000)
    else $error("upper read bits not zero");
  AST_EN_LOW: assert property (
    rd_done && avs_address == `OFF_EN_SYNC
      |-> avs_readdata[4:0] == `EN_SYNC_LOW_BITS)
    else $error("enable register low bits wrong");
  AST_RESET_STATE: assert property (
    $rose(arst_n) |-> short_timer_output && long_timer_output
      && !short_timer_irq && !long_timer_irq)
    else $error("outputs wrong after reset");
  AST_LONG_FORCE: assert property (
    wr_done && avs_address == `OFF_SHARED_MODE
      && !avs_writedata[`BIT_DEMOD] && avs_writedata[`BIT_F_HI]
      |-> ##2 long_timer_output == $past(avs_writedata[`BIT_F_LO], 2))
    else $error("long output not forced");
  AST_LONG_MASK: assert property (
    wr_done && avs_address == `OFF_LONG_CTRL
      && !avs_writedata[`BIT_TIMEOUT_IE] |=> !long_timer_irq)
    else $error("long request not masked");
  AST_SHORT_MASK: assert property (
    wr_done && avs_address == `OFF_SHORT_CTRL
      && !avs_writedata[`BIT_TIMEOUT_IE] && !avs_writedata[`BIT_CAP_IE]
      |=> !short_timer_irq)
    else $error("short request not masked");
endmodule // timer_monitor
bind dual_counter_timer_pulse_unit timer_monitor i_mon (
  .clk(clk), .arst_n(arst_n), .ce(ce), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest),
  .short_timer_output(short_timer_output),
  .long_timer_output(long_timer_output),
  .short_timer_irq(short_timer_irq), .long_timer_irq(long_timer_irq));

// >>> testbench/pulse_source.sv
// Purpose: Pulse source on the two capture pins
// Assumes: Pins change just after the rising clock edge
// Notes:   Pin b toggles every cycle as noise, whichever pin is selected
`timescale 1ns/1ps
module pulse_source (
  // Clock and reset
  input  wire       clk,
  input  wire       arst_n,
  // Commands
  input  wire       start,
  input  wire       glitch,
  input  wire [7:0] width,
  // Pins
  output reg        capture_input_a,
  output reg        capture_input_b
);
  reg [7:0] left;
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      left            <= 8'h00;
      capture_input_a <= 1'b0;
      capture_input_b <= 1'b0;
    end else begin
      capture_input_b <= ~capture_input_b;
      if (start)
        left <= width;
      else if (left != 8'h00)
        left <= left - 8'h01;
      // High for width cycles after start, one cycle for a glitch
      capture_input_a <= glitch || start || left > 8'h01;
    end
  end
endmodule // pulse_source

// >>> testbench/tb_top.sv
// Purpose: Register-level tests of the dual counter/timer unit
// Assumes: One wait state per access, clock enable held high
// Notes:   Pins and responses are sampled on the falling edge
`timescale 1ns/1ps
`include "timer_regs.vh"
module tb_top;
  logic               clk = 1'b0;
  logic               arst_n = 1'b0;
  logic [`ADDR_W-1:0] avs_address = 4'h0;
  logic               avs_read = 1'b0;
  logic               avs_write = 1'b0;
  logic [31:0]        avs_writedata = 32'h0;
  logic               start = 1'b0;
  logic               glitch = 1'b0;
  logic               wq;
  logic [31:0]        rq;
  logic [31:0]        rv;
  wire  [31:0]        avs_readdata;
  wire                avs_waitrequest;
  wire                sto, lto, sirq, lirq, cap_a, cap_b;
  int                 err_total = 0;
  int                 samples_checked = 0;
  int                 c;
  dual_counter_timer_pulse_unit i_dut (
    .clk(clk), .arst_n(arst_n), .ce(1'b1), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .capture_input_a(cap_a),
    .capture_input_b(cap_b), .short_timer_output(sto),
    .long_timer_output(lto), .short_timer_irq(sirq),
    .long_timer_irq(lirq));
  pulse_source i_src (.clk(clk), .arst_n(arst_n), .start(start),
    .glitch(glitch), .width(8'h10), .capture_input_a(cap_a),
    .capture_input_b(cap_b));
  initial forever #2 clk = ~clk;
  // Copies taken mid-cycle equal the values seen at the next rising edge
  always @(negedge clk) begin
    wq <= avs_waitrequest;
    rq <= avs_readdata;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic xfer(input logic w, input logic [3:0] a,
                      input logic [7:0] d);
    int k;
    k = 0;
    @(posedge clk);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= {24'h0, d};
    do begin
      @(posedge clk);
      k++;
    end while (wq !== 1'b0 && k < 20);
    check(k < 20, 1'b1);
    rv = rq;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    xfer(1'b1, a, d);
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    xfer(1'b0, a, 8'h00);
    check(rv, {24'h0, e});
  endtask
  task automatic ticks(input int n);
    repeat (n) @(negedge clk);
  endtask
  // Falling edges until the chosen pin next changes, capped at 600
  task automatic period(input logic lp, output int n);
    logic s;
    s = lp ? lto : sto;
    n = 0;
    while ((lp ? lto : sto) === s && n < 600) begin
      @(negedge clk);
      n++;
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    #100000;
    check(1'b0, 1'b1);
    conclude();
  end
  initial begin
    repeat (10) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    ticks(1);
    check({sto, lto, sirq, lirq}, 4'hc);
    rd(`OFF_EN_SYNC, 8'h1f);
    wr(`OFF_EN_SYNC, 8'h20);
    rd(`OFF_EN_SYNC, 8'h3f);
    rd(4'hc, 8'h00);
    $display("test reset done");
    wr(`OFF_SHORT_LOW_HOLD, 8'h03);
    wr(`OFF_SHORT_CTRL, 8'h42);
    wr(`OFF_EN_SYNC, 8'h40);
    ticks(1);
    check(sto, 1'b0);
    ticks(1);
    check({sto, sirq}, 2'b00);
    ticks(1);
    check({sto, sirq}, 2'b11);
    ticks(8);
    check({sto, sirq}, 2'b11);
    rd(`OFF_SHORT_CTRL, 8'h62);
    wr(`OFF_SHORT_CTRL, 8'h00);
    check(sirq, 1'b0);
    $display("test short single done");
    wr(`OFF_EN_SYNC, 8'h00);
    wr(`OFF_SHORT_LOW_HOLD, 8'h02);
    wr(`OFF_SHORT_HIGH_HOLD, 8'h04);
    wr(`OFF_EN_SYNC, 8'h40);
    ticks(1);
    period(1'b0, c);
    period(1'b0, c);
    check(c, 4);
    period(1'b0, c);
    check(c, 2);
    $display("test short modulo done");
    wr(`OFF_EN_SYNC, 8'h00);
    wr(`OFF_LONG_HOLD_UPPER, 8'h01);
    wr(`OFF_LONG_HOLD_LOWER, 8'h02);
    wr(`OFF_LONG_CTRL, 8'h02);
    wr(`OFF_EN_SYNC, 8'h80);
    ticks(1);
    check(lto, 1'b0);
    period(1'b1, c);
    period(1'b1, c);
    check(c, 258);
    check(lirq, 1'b1);
    rd(`OFF_EN_SYNC, 8'h9f);
    rd(`OFF_LONG_CTRL, 8'h22);
    wr(`OFF_LONG_CTRL, 8'h00);
    check(lirq, 1'b0);
    wr(`OFF_SHARED_MODE, 8'h08);
    ticks(2);
    check(lto, 1'b0);
    wr(`OFF_SHARED_MODE, 8'h0c);
    ticks(2);
    check(lto, 1'b1);
    wr(`OFF_SHARED_MODE, 8'h00);
    wr(`OFF_EN_SYNC, 8'h00);
    rd(`OFF_EN_SYNC, 8'h1f);
    ticks(1);
    check({sto, lto}, 2'b11);
    wr(`OFF_SHARED_MODE, 8'h03);
    ticks(1);
    check({sto, lto}, 2'b00);
    wr(`OFF_SHARED_MODE, 8'h00);
    wr(`OFF_LONG_HOLD_UPPER, 8'h00);
    wr(`OFF_LONG_HOLD_LOWER, 8'h04);
    wr(`OFF_LONG_CTRL, 8'h40);
    wr(`OFF_EN_SYNC, 8'h80);
    ticks(1);
    period(1'b1, c);
    check(c, 3);
    period(1'b1, c);
    check(c, 600);
    rd(`OFF_EN_SYNC, 8'h1f);
    $display("test long done");
    wr(`OFF_EN_SYNC, 8'h00);
    wr(`OFF_SHARED_MODE, 8'hb4);
    wr(`OFF_SHORT_CTRL, 8'h24);
    wr(`OFF_EN_SYNC, 8'h40);
    glitch <= 1'b1;
    @(posedge clk);
    glitch <= 1'b0;
    ticks(6);
    rd(`OFF_SHARED_MODE, 8'hb4);
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    ticks(30);
    rd(`OFF_SHORT_CAP_HIGH, 8'hf0);
    wr(`OFF_SHORT_CAP_HIGH, 8'h55);
    rd(`OFF_SHORT_CAP_HIGH, 8'hf0);
    rd(`OFF_SHARED_MODE, 8'hb7);
    check(sirq, 1'b1);
    rd(`OFF_SHORT_CTRL, 8'h04);
    ticks(300);
    rd(`OFF_SHORT_CTRL, 8'h24);
    wr(`OFF_SHARED_MODE, 8'hf7);
    ticks(10);
    rd(`OFF_SHARED_MODE, 8'hf4);
    wr(`OFF_SHARED_MODE, 8'hf0);
    ticks(4);
    rd(`OFF_SHARED_MODE, 8'hf3);
    wr(`OFF_SHORT_CTRL, 8'h00);
    $display("test demod done");
    conclude();
  end
endmodule // tb_top
